// file: src/p6_xmii_map.svh
`ifndef P6_XMII_MAP_SVH
`define P6_XMII_MAP_SVH

// Pin input synchroniser depth
`define P6_SYNC_DEPTH 3
// Slow speed clock ratio (25 to 2.5, 125 to 12.5 per half period step)
`define P6_SLOW_RATIO 4'hA
// Reset value of every output enable (not driving)
`define P6_OEN_RESET 1'b1
// Reset value of data and qualifier pins
`define P6_PIN_RESET 1'b0
// Data mask for RMII (bits 1 and 0) and for four-bit modes
`define P6_MASK_RMII 4'h3
`define P6_MASK_FULL 4'hF
// Entries of the transmit buffer
`define P6_BUF_DEPTH 2

`endif

// file: src/p6_xmii_pkg.sv
package p6_xmii_pkg;
	// Interface mode
	typedef enum logic [1:0] {
		MODE_MII   = 2'b00,
		MODE_RMII  = 2'b01,
		MODE_RGMII = 2'b10
	} mode_e;
	// Role of the documented device
	typedef enum logic {
		ROLE_PHY = 1'b0,
		ROLE_MAC = 1'b1
	} role_e;
	// RMII reference clock sub-mode
	typedef enum logic {
		RMII_NORMAL = 1'b0,
		RMII_CLOCK  = 1'b1
	} rmii_e;
	// Data nibble on the pins
	typedef logic [3:0] nibble_t;
	// Word in the transmit buffer: error flag and nibble
	typedef struct packed {
		logic    err;
		nibble_t data;
	} txword_s;
endpackage : p6_xmii_pkg

// file: src/p6_xmii_if.sv
`timescale 1ns/1ps
`default_nettype none
interface p6_xmii_if;
	import p6_xmii_pkg::*;
	// Two-way pins: output, active-low enable from each end
	logic    devTxClkO, devTxClkOeN, farTxClkO, farTxClkOeN;
	logic    devRxClkO, devRxClkOeN, farRxClkO, farRxClkOeN;
	logic    devColO, devColOeN, farColO, farColOeN;
	logic    devCrsO, devCrsOeN, farCrsO, farCrsOeN;
	// Resolved wire levels (undriven reads low, as the pull-down)
	logic    p6TransmitClock;
	logic    p6ReceiveClock;
	logic    p6CollisionDetect;
	logic    p6CarrierSense;
	// Far end to device: enable (MII/RMII) or control (RGMII)
	logic    p6TransmitEnable;
	logic    p6TransmitError;
	nibble_t p6TxData;
	// Device to far end: valid, sense-and-valid or control
	logic    p6ReceiveValid;
	logic    p6ReceiveError;
	nibble_t p6RxData;

	function automatic logic resolve(input logic a, input logic aOeN,
		input logic b, input logic bOeN);
		resolve = !aOeN ? a : (!bOeN ? b : 1'b0);
	endfunction : resolve

	assign p6TransmitClock   = resolve(devTxClkO, devTxClkOeN,
		farTxClkO, farTxClkOeN);
	assign p6ReceiveClock    = resolve(devRxClkO, devRxClkOeN,
		farRxClkO, farRxClkOeN);
	assign p6CollisionDetect = resolve(devColO, devColOeN,
		farColO, farColOeN);
	assign p6CarrierSense    = resolve(devCrsO, devCrsOeN,
		farCrsO, farCrsOeN);

	modport device (
		output devTxClkO, devTxClkOeN, devRxClkO, devRxClkOeN,
		output devColO, devColOeN, devCrsO, devCrsOeN,
		output p6ReceiveValid, p6ReceiveError, p6RxData,
		input  p6TransmitClock, p6ReceiveClock,
		input  p6CollisionDetect, p6CarrierSense,
		input  p6TransmitEnable, p6TransmitError, p6TxData
	);
	modport far (
		output farTxClkO, farTxClkOeN, farRxClkO, farRxClkOeN,
		output farColO, farColOeN, farCrsO, farCrsOeN,
		output p6TransmitEnable, p6TransmitError, p6TxData,
		input  p6TransmitClock, p6ReceiveClock,
		input  p6CollisionDetect, p6CarrierSense,
		input  p6ReceiveValid, p6ReceiveError, p6RxData
	);
endinterface : p6_xmii_if
`default_nettype wire

// file: src/p6_two_entry_buf.sv
`timescale 1ns/1ps
`default_nettype none
`include "p6_xmii_map.svh"
module p6_two_entry_buf #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Filling side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	// Draining side
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	// Entry storage, addressed by the pointers
	logic [WIDTH-1:0] mem_q [`P6_BUF_DEPTH];
	logic             wrPtr_q;
	logic             rdPtr_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	// Full and empty follow the true count, so a stall really fills it
	assign inReady  = (count_q != 2'h2);
	assign outValid = (count_q != 2'h0);
	assign outData  = mem_q[rdPtr_q];

	// Write side
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= 1'b0;
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wrPtr_q] <= inData;
			wrPtr_q <= !wrPtr_q;
		end
	end

	// Read side and occupancy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdPtr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (pop) begin
				rdPtr_q <= !rdPtr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : p6_two_entry_buf
`default_nettype wire

// file: src/p6_xmii_device.sv
// Overview of operation
// - MII clocks: 25 MHz fast, 2.5 MHz slow
// - MII PHY drives clocks, collision, sense
// - RMII Normal: far end supplies reference clock
// - RMII Clock: device drives reference clock out
// - RGMII: transmit clock in, receive clock out
// - Transmit qualifier is enable, or control in RGMII
// - Transmit error sampled only in MII
// - Receive error driven only in MII
// - Transmit data: RMII uses bits 1..0 only
// - Receive data: RMII drives bits 1..0 only
`timescale 1ns/1ps
`default_nettype none
`include "p6_xmii_map.svh"
module p6_xmii_device (
	// Link clock and reset
	input  wire logic                linkClk,
	input  wire logic                nrst,
	// Static configuration
	input  wire p6_xmii_pkg::mode_e  mode,
	input  wire p6_xmii_pkg::role_e  role,
	input  wire p6_xmii_pkg::rmii_e  rmiiSub,
	input  wire logic                speedSlow,
	// Link pins
	p6_xmii_if.device                link,
	// Words taken from the far end's transmit path
	output p6_xmii_pkg::txword_s     txWord,
	output logic                     txWordValid,
	input  wire logic                txWordReady,
	output logic                     txOverrun,
	// Nibbles to send on the receive path
	input  wire p6_xmii_pkg::nibble_t rxNibble,
	input  wire logic                rxValid,
	input  wire logic                rxErr,
	input  wire logic                rxCarrier,
	output logic                     rxReady
);
	import p6_xmii_pkg::*;

	// Data mask per mode, used on both data paths
	function automatic nibble_t dataMask(input mode_e m);
		dataMask = (m == MODE_RMII) ? `P6_MASK_RMII : `P6_MASK_FULL;
	endfunction : dataMask

	// Synchroniser stages: {crs, col, err, en, data}
	logic [7:0] sync_q [`P6_SYNC_DEPTH];
	logic [7:0] acc_q;          // Accepted, settled pin levels
	logic [3:0] divCnt_q;       // Clock divider count
	logic       clkOut_q;       // Forwarded interface clock
	logic       txClkOeN_q;
	logic       rxClkOeN_q;
	logic       colCrsOeN_q;
	logic       col_q;
	logic       crs_q;
	logic       rxDv_q;
	logic       rxEr_q;
	nibble_t    rxData_q;
	logic       overrun_q;
	logic       rxReady_q;
	logic       bufInReady;
	txword_s    pushWord;
	logic       pushValid;
	logic       isMii;
	logic       isPhyMii;
	logic       accEn;
	logic       settled;        // Last two stages agree this cycle

	assign isMii    = (mode == MODE_MII);
	assign isPhyMii = isMii && (role == ROLE_PHY);
	assign accEn    = acc_q[4];
	assign settled  = (sync_q[1] == sync_q[2]);

	// Three-flop pin synchroniser; the first stage feeds only the second
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `P6_SYNC_DEPTH; i++) begin
				sync_q[i] <= 8'h00;
			end
		end else begin
			sync_q[0] <= {link.p6CarrierSense, link.p6CollisionDetect,
				link.p6TransmitError, link.p6TransmitEnable,
				link.p6TxData};
			for (int i = 1; i < `P6_SYNC_DEPTH; i++) begin
				sync_q[i] <= sync_q[i-1];
			end
		end
	end

	// A change counts once the last two stages agree
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= 8'h00;
		end else if (sync_q[1] == sync_q[2]) begin
			acc_q <= sync_q[2];
		end
	end

	// Interface clock divider; ratio 10 gives the slow rate
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			divCnt_q <= 4'h0;
			clkOut_q <= 1'b0;
		end else if (speedSlow && !(mode == MODE_RMII)) begin
			// Slow rate: 2.5 MHz from 25, or 12.5 from 125
			if (divCnt_q == `P6_SLOW_RATIO - 4'h1) begin
				divCnt_q <= 4'h0;
				clkOut_q <= !clkOut_q;
			end else begin
				divCnt_q <= divCnt_q + 4'h1;
			end
		end else begin
			// Fast rate; RMII reference clock is always full rate
			divCnt_q <= 4'h0;
			clkOut_q <= !clkOut_q;
		end
	end

	// Pin directions follow mode and role, held in flops
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			txClkOeN_q  <= `P6_OEN_RESET;
			rxClkOeN_q  <= `P6_OEN_RESET;
			colCrsOeN_q <= `P6_OEN_RESET;
		end else begin
			// Transmit clock pin is an input in RMII and RGMII
			txClkOeN_q  <= !isPhyMii;
			// Receive clock pin: PHY MII, RMII Clock, RGMII
			rxClkOeN_q  <= !(isPhyMii || mode == MODE_RGMII ||
				(mode == MODE_RMII && rmiiSub == RMII_CLOCK));
			// Collision and sense exist only as PHY in MII
			colCrsOeN_q <= !isPhyMii;
		end
	end

	// Collision and carrier sense, only meaningful in MII
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			col_q <= `P6_PIN_RESET;
			crs_q <= `P6_PIN_RESET;
		end else if (isPhyMii) begin
			crs_q <= rxValid || accEn;
			col_q <= rxValid && accEn;
		end else begin
			crs_q <= `P6_PIN_RESET;
			col_q <= `P6_PIN_RESET;
		end
	end

	// Transmit path: qualifier is enable or control, same pin
	// One word per settled cycle: the filter needs a level to stand two
	// edges, so the far end holds a word two cycles and it counts once
	always_comb begin
		pushValid     = settled && sync_q[2][4];
		pushWord.data = sync_q[2][3:0] & dataMask(mode);
		// Error input has no function outside MII
		pushWord.err  = sync_q[2][5] && isMii;
	end

	// The buffer absorbs a core stall; a full buffer drops and flags
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			overrun_q <= 1'b0;
		end else if (pushValid && !bufInReady) begin
			overrun_q <= 1'b1;
		end
	end

	p6_two_entry_buf #(
		.WIDTH ($bits(txword_s))
	) i_p6_two_entry_buf (
		.clk      (linkClk),
		.nrst     (nrst),
		.inData   (pushWord),
		.inValid  (pushValid),
		.inReady  (bufInReady),
		.outData  (txWord),
		.outValid (txWordValid),
		.outReady (txWordReady)
	);

	// Receive path: one nibble each cycle, always ready after reset
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			rxReady_q <= 1'b0;
			rxDv_q    <= `P6_PIN_RESET;
			rxEr_q    <= `P6_PIN_RESET;
			rxData_q  <= 4'h0;
		end else begin
			rxReady_q <= 1'b1;
			rxData_q  <= rxValid ? (rxNibble & dataMask(mode)) : 4'h0;
			// Error pin is unused outside MII
			rxEr_q    <= rxValid && rxErr && isMii;
			unique case (mode)
				MODE_MII:   rxDv_q <= rxValid;
				// Sense and valid: carrier or data, merged on one pin
				MODE_RMII:  rxDv_q <= rxValid || rxCarrier;
				// Control carries valid; error half is not modelled
				MODE_RGMII: rxDv_q <= rxValid;
				default:    rxDv_q <= `P6_PIN_RESET;
			endcase
		end
	end

	// Pin drives, all from flops
	assign link.devTxClkO     = clkOut_q;
	assign link.devTxClkOeN   = txClkOeN_q;
	assign link.devRxClkO     = clkOut_q;
	assign link.devRxClkOeN   = rxClkOeN_q;
	assign link.devColO       = col_q;
	assign link.devColOeN     = colCrsOeN_q;
	assign link.devCrsO       = crs_q;
	assign link.devCrsOeN     = colCrsOeN_q;
	assign link.p6ReceiveValid = rxDv_q;
	assign link.p6ReceiveError = rxEr_q;
	assign link.p6RxData      = rxData_q;
	assign txOverrun          = overrun_q;
	assign rxReady            = rxReady_q;
endmodule : p6_xmii_device
`default_nettype wire

// file: src/p6_xmii_far.sv
`timescale 1ns/1ps
`default_nettype none
`include "p6_xmii_map.svh"
module p6_xmii_far (
	// Clocks and reset
	input  wire logic                 ref_clk,
	input  wire logic                 linkClk,
	input  wire logic                 nrst,
	// Static configuration, same values as the device
	input  wire p6_xmii_pkg::mode_e   mode,
	input  wire p6_xmii_pkg::role_e   role,
	input  wire p6_xmii_pkg::rmii_e   rmiiSub,
	// Link pins
	p6_xmii_if.far                    link,
	// Transmit request, ref_clk side
	input  wire p6_xmii_pkg::nibble_t txNibble,
	input  wire logic                 txErr,
	input  wire logic                 txValid,
	output logic                      txReady,
	// Received nibble, ref_clk side
	output p6_xmii_pkg::nibble_t      rxNibble,
	output logic                      rxErr,
	output logic                      rxValid
);
	import p6_xmii_pkg::*;

	logic    req_q, ackSeen_q, txReady_q;   // ref_clk side
	logic    txErrH_q;                      // Held for the crossing
	nibble_t txDataH_q;
	logic [`P6_SYNC_DEPTH-1:0] ackS_q;      // Ack into ref_clk
	logic [`P6_SYNC_DEPTH-1:0] reqS_q;      // Request into linkClk
	logic    reqDone_q, ack_q;              // linkClk side
	logic    txEn_q, txEr_q;
	logic    txHold_q;                      // Second cycle of a word
	nibble_t txData_q;
	logic [5:0] rxS_q [`P6_SYNC_DEPTH];     // {err, dv, data} pins
	logic    rxTog_q, rxErrH_q;
	nibble_t rxDataH_q;
	logic [`P6_SYNC_DEPTH-1:0] rxTogS_q;    // Toggle into ref_clk
	logic    rxSeen_q, rxValid_q, rxErr_q;
	nibble_t rxNibble_q;
	logic    clkOut_q, drvTxClkOeN_q, drvRxOeN_q;
	logic    isMacMii;

	assign isMacMii = (mode == MODE_MII) && (role == ROLE_MAC);

	// Request side: hold the word, toggle, wait for the ack toggle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			req_q <= 1'b0;
			txReady_q <= 1'b0;
			txErrH_q <= 1'b0;
			txDataH_q <= 4'h0;
			ackS_q <= '0;
			ackSeen_q <= 1'b0;
		end else begin
			ackS_q <= {ackS_q[`P6_SYNC_DEPTH-2:0], ack_q};
			if (ackS_q[1] == ackS_q[2]) begin
				ackSeen_q <= ackS_q[2];
			end
			if (txValid && txReady_q) begin
				txDataH_q <= txNibble;
				txErrH_q <= txErr;
				req_q <= !req_q;
				txReady_q <= 1'b0;
			end else if (!txReady_q && ackSeen_q == req_q) begin
				txReady_q <= 1'b1;
			end
		end
	end

	// Link side: a new request drives two cycles of enable and data
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			reqS_q <= '0;
			reqDone_q <= 1'b0;
			ack_q <= 1'b0;
			txEn_q <= 1'b0;
			txEr_q <= 1'b0;
			txData_q <= 4'h0;
			txHold_q <= 1'b0;
		end else begin
			reqS_q <= {reqS_q[`P6_SYNC_DEPTH-2:0], req_q};
			if (reqS_q[1] == reqS_q[2] && reqS_q[2] != reqDone_q) begin
				reqDone_q <= reqS_q[2];
				ack_q <= reqS_q[2];
				txEn_q <= 1'b1;
				txHold_q <= 1'b1;
				// Bits 3 and 2 are left low in RMII
				txData_q <= (mode == MODE_RMII) ?
					(txDataH_q & `P6_MASK_RMII) : txDataH_q;
				txEr_q <= txErrH_q && (mode == MODE_MII);
			end else if (txHold_q) begin
				// Hold one more edge: the receiver filters one-cycle glitches
				txHold_q <= 1'b0;
			end else begin
				txEn_q <= 1'b0;
				txEr_q <= 1'b0;
				txData_q <= 4'h0;
			end
		end
	end

	// Receive pins: three flops, settle, then hold and toggle
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `P6_SYNC_DEPTH; i++) begin
				rxS_q[i] <= 6'h00;
			end
			rxTog_q <= 1'b0;
			rxErrH_q <= 1'b0;
			rxDataH_q <= 4'h0;
		end else begin
			rxS_q[0] <= {link.p6ReceiveError, link.p6ReceiveValid,
				link.p6RxData};
			for (int i = 1; i < `P6_SYNC_DEPTH; i++) begin
				rxS_q[i] <= rxS_q[i-1];
			end
			if (rxS_q[1] == rxS_q[2] && rxS_q[2][4]) begin
				rxDataH_q <= rxS_q[2][3:0];
				rxErrH_q <= rxS_q[2][5];
				rxTog_q <= !rxTog_q;
			end
		end
	end

	// Ref side: each settled toggle change is one received nibble
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxTogS_q <= '0;
			rxSeen_q <= 1'b0;
			rxValid_q <= 1'b0;
			rxErr_q <= 1'b0;
			rxNibble_q <= 4'h0;
		end else begin
			rxTogS_q <= {rxTogS_q[`P6_SYNC_DEPTH-2:0], rxTog_q};
			rxValid_q <= 1'b0;
			if (rxTogS_q[1] == rxTogS_q[2] && rxTogS_q[2] != rxSeen_q) begin
				rxSeen_q <= rxTogS_q[2];
				rxValid_q <= 1'b1;
				rxNibble_q <= rxDataH_q;
				rxErr_q <= rxErrH_q;
			end
		end
	end

	// Clock and direction drives for the pins the far end owns
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			clkOut_q <= 1'b0;
			drvTxClkOeN_q <= `P6_OEN_RESET;
			drvRxOeN_q <= `P6_OEN_RESET;
		end else begin
			clkOut_q <= !clkOut_q;
			// MAC-role MII, RMII Normal reference, RGMII transmit clock
			drvTxClkOeN_q <= !(isMacMii || mode == MODE_RGMII ||
				(mode == MODE_RMII && rmiiSub == RMII_NORMAL));
			drvRxOeN_q <= !isMacMii;
		end
	end

	assign link.farTxClkO  = clkOut_q;
	assign link.farTxClkOeN = drvTxClkOeN_q;
	assign link.farRxClkO  = clkOut_q;
	assign link.farRxClkOeN = drvRxOeN_q;
	assign link.farColO    = 1'b0;
	assign link.farColOeN  = drvRxOeN_q;
	assign link.farCrsO    = txEn_q;
	assign link.farCrsOeN  = drvRxOeN_q;
	assign link.p6TransmitEnable = txEn_q;
	assign link.p6TransmitError  = txEr_q;
	assign link.p6TxData   = txData_q;
	assign txReady  = txReady_q;
	assign rxNibble = rxNibble_q;
	assign rxErr    = rxErr_q;
	assign rxValid  = rxValid_q;
endmodule : p6_xmii_far
`default_nettype wire

// file: dv/p6_xmii_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module p6_xmii_monitor (
	// Link clock and reset
	input wire logic                linkClk,
	input wire logic                nrst,
	// Static configuration
	input wire p6_xmii_pkg::mode_e  mode,
	input wire p6_xmii_pkg::role_e  role,
	input wire p6_xmii_pkg::rmii_e  rmiiSub,
	input wire logic                speedSlow,
	// Device pin drives
	input wire logic                devTxClkO,
	input wire logic                devTxClkOeN,
	input wire logic                devRxClkO,
	input wire logic                devRxClkOeN,
	input wire logic                devColOeN,
	input wire logic                devCrsOeN,
	input wire logic                p6ReceiveError,
	input wire p6_xmii_pkg::nibble_t p6RxData
);
	import p6_xmii_pkg::*;
	// One domain only; the past of nrst hides the first edge after release
	default clocking cb @(posedge linkClk);
	endclocking
	default disable iff (!nrst);

	chk_phy_drive: assert property (
		$past(nrst) && mode == MODE_MII && role == ROLE_PHY |->
		!devTxClkOeN && !devRxClkOeN && !devColOeN && !devCrsOeN)
		else $error("PHY role leaves an MII pin undriven");
	chk_mac_listens: assert property (
		mode == MODE_MII && role == ROLE_MAC |->
		devTxClkOeN && devRxClkOeN && devColOeN && devCrsOeN)
		else $error("MAC role drives an MII input pin");
	chk_refclk_in: assert property (
		mode == MODE_RMII && rmiiSub == RMII_NORMAL |->
		devTxClkOeN && devRxClkOeN)
		else $error("RMII normal drives a clock pin");
	chk_refclk_out: assert property (
		$past(nrst) && mode == MODE_RMII && rmiiSub == RMII_CLOCK |->
		!devRxClkOeN && devTxClkOeN)
		else $error("RMII clock mode reference pin wrong");
	chk_rgmii_clocks: assert property (
		$past(nrst) && mode == MODE_RGMII |-> devTxClkOeN && !devRxClkOeN)
		else $error("RGMII clock directions wrong");
	// Fast clocks toggle on every link edge
	chk_rx_clk_fast: assert property (
		$past(nrst) && !devRxClkOeN && (mode == MODE_RMII || !speedSlow)
		|-> devRxClkO != $past(devRxClkO))
		else $error("receive clock missed a toggle");
	chk_tx_clk_fast: assert property (
		$past(nrst) && !devTxClkOeN && !speedSlow
		|-> devTxClkO != $past(devTxClkO))
		else $error("transmit clock missed a toggle");
	// Slow speed: receive clock holds for nine link edges after each toggle, eight of them checked
	chk_rx_clk_slow: assert property (
		$past(nrst) && !devRxClkOeN && mode != MODE_RMII && speedSlow
		&& $changed(devRxClkO) |=> $stable(devRxClkO)[*8])
		else $error("slow receive clock toggles too soon");
	chk_col_unused: assert property (
		mode != MODE_MII |-> devColOeN && devCrsOeN)
		else $error("collision or sense driven outside MII");
	chk_rx_error: assert property (
		mode != MODE_MII |-> !p6ReceiveError)
		else $error("receive error driven outside MII");
	chk_rmii_rxdata: assert property (
		mode == MODE_RMII |-> p6RxData[3:2] == 2'h0)
		else $error("RMII drives receive bits 3 and 2");
endmodule : p6_xmii_monitor
`default_nettype wire

// file: dv/port6_xmii_pin_mode_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port6_xmii_pin_mode_map_tb;
	import p6_xmii_pkg::*;
	// Clocks, reset and configuration
	logic    ref_clk, linkClk, nrst, speedSlow;
	mode_e   mode;
	role_e   role;
	rmii_e   rmiiSub;
	// Device user side
	txword_s txWord;
	logic    txWordValid, txWordReady, txOverrun, rxReady;
	nibble_t devRxNibble;
	logic    devRxValid, devRxErr, rxCarrier;
	// Far user side
	nibble_t txNibble, farRxNibble;
	logic    txErr, txValid, txReady, farRxErr, farRxValid;
	int      fails, n_checks;
	// Configurations visited, one reset each
	mode_e   cfgMode [6] = '{MODE_MII, MODE_MII, MODE_RMII, MODE_RMII,
		MODE_RGMII, MODE_RGMII};
	role_e   cfgRole [6] = '{ROLE_PHY, ROLE_MAC, ROLE_PHY, ROLE_PHY,
		ROLE_PHY, ROLE_MAC};
	rmii_e   cfgSub  [6] = '{RMII_NORMAL, RMII_NORMAL, RMII_NORMAL,
		RMII_CLOCK, RMII_NORMAL, RMII_NORMAL};
	logic    cfgSlow [6] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1};

	// User clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Link clock, offset so its edges never meet ref_clk edges
	initial begin
		linkClk = 1'b0;
		#7;
		forever #80 linkClk = ~linkClk;
	end

	p6_xmii_if link ();
	p6_xmii_device i_p6_xmii_device (.linkClk(linkClk), .nrst(nrst),
		.mode(mode), .role(role), .rmiiSub(rmiiSub), .speedSlow(speedSlow),
		.link(link.device), .txWord(txWord), .txWordValid(txWordValid),
		.txWordReady(txWordReady), .txOverrun(txOverrun),
		.rxNibble(devRxNibble), .rxValid(devRxValid), .rxErr(devRxErr),
		.rxCarrier(rxCarrier), .rxReady(rxReady));
	p6_xmii_far i_p6_xmii_far (.ref_clk(ref_clk), .linkClk(linkClk),
		.nrst(nrst), .mode(mode), .role(role), .rmiiSub(rmiiSub),
		.link(link.far), .txNibble(txNibble), .txErr(txErr),
		.txValid(txValid), .txReady(txReady), .rxNibble(farRxNibble),
		.rxErr(farRxErr), .rxValid(farRxValid));
	p6_xmii_monitor i_p6_xmii_monitor (.linkClk(linkClk), .nrst(nrst),
		.mode(mode), .role(role), .rmiiSub(rmiiSub), .speedSlow(speedSlow),
		.devTxClkO(link.devTxClkO), .devTxClkOeN(link.devTxClkOeN),
		.devRxClkO(link.devRxClkO), .devRxClkOeN(link.devRxClkOeN),
		.devColOeN(link.devColOeN), .devCrsOeN(link.devCrsOeN),
		.p6ReceiveError(link.p6ReceiveError), .p6RxData(link.p6RxData));

	// Verdict and end of run
	task automatic results();
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// A wait that ran out counts against the run and ends it
	task automatic hang();
		fails++;
		$display("unexpected at %0t: wait ran out", $time);
		results();
	endtask : hang

	// Compare an error flag plus nibble
	task automatic checkWord(input logic [4:0] got, input logic [4:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: word %h not %h", $time, got, exp);
		end
	endtask : checkWord

	// Compare a single flag
	task automatic checkFlag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: flag %b not %b", $time, got, exp);
		end
	endtask : checkFlag

	// What crosses the pins: error only in MII, two bits in RMII
	function automatic logic [4:0] expWord(input nibble_t d, input logic e);
		expWord = {mode == MODE_MII && e, mode == MODE_RMII ? (d & 4'h3) : d};
	endfunction : expWord

	// Far end sends one nibble; request held until txReady is seen
	task automatic sendTx(input nibble_t d, input logic e);
		int i;
		@(posedge ref_clk);
		txNibble <= d;
		txErr    <= e;
		txValid  <= 1'b1;
		for (i = 0; i < 400; i++) begin
			@(posedge ref_clk);
			if (txReady === 1'b1) break;
		end
		if (i == 400) hang();
		txValid <= 1'b0;
	endtask : sendTx

	// Device user takes the buffer head
	task automatic pop(input logic [4:0] exp);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge linkClk);
			if (txWordValid === 1'b1) break;
		end
		if (i == 400) hang();
		checkWord(txWord, exp);
		txWordReady <= 1'b1;
		@(posedge linkClk);
		txWordReady <= 1'b0;
	endtask : pop

	// Device sends one nibble, far end must report it
	task automatic sendRx(input nibble_t d);
		int i;
		@(posedge linkClk);
		devRxNibble <= d;
		devRxValid  <= 1'b1;
		devRxErr    <= 1'b1;
		// Two edges: the far end's filter ignores a one-cycle level
		repeat (2) @(posedge linkClk);
		devRxValid  <= 1'b0;
		for (i = 0; i < 400; i++) begin
			@(posedge ref_clk);
			if (farRxValid === 1'b1) break;
		end
		if (i == 400) hang();
		checkWord({farRxErr, farRxNibble}, expWord(d, 1'b1));
	endtask : sendRx

	// Main sequence: every mode, role and sub-mode in turn
	initial begin
		int k;
		int i;
		fails = 0;
		n_checks = 0;
		nrst = 1'b0;
		{speedSlow, txWordReady, devRxValid, devRxErr, rxCarrier} = 5'h00;
		{txErr, txValid} = 2'h0;
		devRxNibble = 4'h0;
		txNibble = 4'h0;
		mode = MODE_MII;
		role = ROLE_PHY;
		rmiiSub = RMII_NORMAL;
		for (k = 0; k < 6; k++) begin
			@(posedge ref_clk);
			nrst      <= 1'b0;
			mode      <= cfgMode[k];
			role      <= cfgRole[k];
			rmiiSub   <= cfgSub[k];
			speedSlow <= cfgSlow[k];
			repeat (8) @(posedge ref_clk);
			nrst <= 1'b1;
			repeat (3) @(posedge linkClk);
			checkFlag(rxReady, 1'b1);
			sendRx(4'hE);
			sendRx(4'h5);
			// Receiver stalls: two words fit, the third is lost
			sendTx(4'hD, 1'b1);
			sendTx(4'h6, 1'b0);
			sendTx(4'hB, 1'b1);
			for (i = 0; i < 400; i++) begin
				@(posedge linkClk);
				if (txOverrun === 1'b1) break;
			end
			if (i == 400) hang();
			checkFlag(txOverrun, 1'b1);
			pop(expWord(4'hD, 1'b1));
			pop(expWord(4'h6, 1'b0));
			repeat (2) @(posedge linkClk);
			checkFlag(txWordValid, 1'b0);
			// Carrier alone qualifies receive only in RMII
			rxCarrier <= 1'b1;
			repeat (2) @(posedge linkClk);
			checkFlag(link.p6ReceiveValid, mode == MODE_RMII);
			rxCarrier <= 1'b0;
		end
		results();
	end
endmodule : port6_xmii_pin_mode_map_tb
`default_nettype wire
